// ---- hw/converter_core_trim_bank.sv ----
// trim register bank with axi4-lite access and per-core trim routing
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps

// What this block does
// - core b timing trim, single, input a
// - core a timing trim, single, input b
// - core b timing trim, single, input b
// - core a offset, dual, input a
// - core a offset, dual, input b
// - core a offset, single, input a
// - timing trims steer their core's sampling instant
// - factory values loaded, readable and overwritable
module converter_core_trim_bank (
    input wire logic clock,
    input wire logic rstn,
    input wire trim_bank_pkg::axi_req_s axi_req,
    output trim_bank_pkg::axi_resp_s axi_resp,
    input wire trim_bank_pkg::fuse_trims_s fuse_trims,
    output trim_bank_pkg::core_trims_s core_trims
);
    import trim_bank_pkg::*;

    // ***********************************************************
    // helpers
    // ***********************************************************
    // word index of a byte address
    function automatic logic [IDX_W-1:0] addr_index(
        input logic [ADDR_W-1:0] a
    );
        addr_index = a[ADDR_W-1:2];
    endfunction

    // aligned and one of the mapped words
    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        logic [IDX_W-1:0] i;
        i = a[ADDR_W-1:2];
        is_mapped = (a[1:0] == 2'h0) &&
            (i == IDX_B_TIME_IN_A || i == IDX_A_TIME_IN_B ||
             i == IDX_B_TIME_IN_B || i == IDX_A_OFS_DUAL_A ||
             i == IDX_A_OFS_DUAL_B || i == IDX_A_OFS_SINGLE_A ||
             i == IDX_MODE_CTRL || i == IDX_TRIM_STATUS);
    endfunction

    // byte lanes 0 and 1 merged into a 16-bit word
    function automatic logic [OFS_REG_W-1:0] merge16(
        input logic [OFS_REG_W-1:0] old,
        input logic [DATA_W-1:0] d,
        input logic [3:0] s
    );
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // ***********************************************************
    // state
    // ***********************************************************
    fuse_trims_s fuse_meta_reg;     // first sync stage, read only by next
    fuse_trims_s fuse_sync_reg;     // second sync stage
    logic [1:0] load_cnt_reg;       // cycles since reset release
    logic loaded_reg;               // factory values are in place
    logic [TIME_W-1:0] b_time_in_a_reg;
    logic [TIME_W-1:0] a_time_in_b_reg;
    logic [TIME_W-1:0] b_time_in_b_reg;
    logic [OFS_REG_W-1:0] a_ofs_dual_a_reg;
    logic [OFS_REG_W-1:0] a_ofs_dual_b_reg;
    logic [OFS_REG_W-1:0] a_ofs_single_a_reg;
    logic [CTRL_W-1:0] mode_ctrl_reg;   // channel mode, cal, input selects
    core_trims_s core_trims_reg;        // trims driven to the cores
    core_trims_s core_trims_next;

    // bus state
    logic aw_held_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic w_held_reg;
    logic [DATA_W-1:0] wdata_reg;
    logic [3:0] wstrb_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic [1:0] rresp_reg;

    // ***********************************************************
    // decode and selection
    // ***********************************************************
    wire aw_take = axi_req.awvalid & awready_reg;
    wire w_take = axi_req.wvalid & wready_reg;
    wire ar_take = axi_req.arvalid & arready_reg;
    // write fires once address and data are both held and b is free
    wire do_write = aw_held_reg & w_held_reg & ~bvalid_reg;
    wire wr_ok = do_write & is_mapped(awaddr_reg);
    wire [IDX_W-1:0] wr_idx = addr_index(awaddr_reg);
    wire [IDX_W-1:0] rd_idx = addr_index(axi_req.araddr);
    wire aw_held_next = aw_held_reg ? ~do_write : aw_take;
    wire w_held_next = w_held_reg ? ~do_write : w_take;
    wire bvalid_next = do_write | (bvalid_reg & ~axi_req.bready);
    wire rvalid_next = ar_take | (rvalid_reg & ~axi_req.rready);
    wire fuse_load = ~loaded_reg & (load_cnt_reg == FUSE_LOAD_CYCLES);

    // mode decode
    wire single_mode = mode_ctrl_reg[CTRL_SINGLE_BIT];
    wire fg_cal = mode_ctrl_reg[CTRL_FG_CAL_BIT];
    wire a_in_b = mode_ctrl_reg[CTRL_A_IN_B_BIT];
    wire b_in_b = mode_ctrl_reg[CTRL_B_IN_B_BIT];
    wire single_fg = single_mode & fg_cal;
    wire dual_fg = ~single_mode & fg_cal;

    // read mux, narrow registers sit low with zero above
    wire [STAT_W-1:0] status_word = {loaded_reg, core_trims_reg.a_offset_valid,
        core_trims_reg.b_time_valid, core_trims_reg.a_time_valid};
    wire [DATA_W-1:0] rd_word =
        (rd_idx == IDX_B_TIME_IN_A) ? {24'h000000, b_time_in_a_reg} :
        (rd_idx == IDX_A_TIME_IN_B) ? {24'h000000, a_time_in_b_reg} :
        (rd_idx == IDX_B_TIME_IN_B) ? {24'h000000, b_time_in_b_reg} :
        (rd_idx == IDX_A_OFS_DUAL_A) ? {16'h0000, a_ofs_dual_a_reg} :
        (rd_idx == IDX_A_OFS_DUAL_B) ? {16'h0000, a_ofs_dual_b_reg} :
        (rd_idx == IDX_A_OFS_SINGLE_A) ? {16'h0000, a_ofs_single_a_reg} :
        (rd_idx == IDX_MODE_CTRL) ? {28'h0000000, mode_ctrl_reg} :
        (rd_idx == IDX_TRIM_STATUS) ? {28'h0000000, status_word} :
        32'h00000000;

    // ***********************************************************
    // trim routing: one register per core, only in its own mode
    // ***********************************************************
    // core a timing: single channel sampling input b
    // named wire, so the struct never reads back its own member
    wire a_time_on = single_fg & a_in_b;
    assign core_trims_next.a_time_valid = a_time_on;
    assign core_trims_next.a_time = a_time_on ?
        a_time_in_b_reg : TIME_RESET;
    // core b timing: single channel, input picks the register
    assign core_trims_next.b_time_valid = single_fg;
    assign core_trims_next.b_time = ~single_fg ? TIME_RESET :
        b_in_b ? b_time_in_b_reg : b_time_in_a_reg;
    // core a offset: dual by input, single only for input a
    assign core_trims_next.a_offset_valid =
        dual_fg | (single_fg & ~a_in_b);
    assign core_trims_next.a_offset =
        (dual_fg & ~a_in_b) ? a_ofs_dual_a_reg[OFS_W-1:0] :
        (dual_fg & a_in_b) ? a_ofs_dual_b_reg[OFS_W-1:0] :
        (single_fg & ~a_in_b) ? a_ofs_single_a_reg[OFS_W-1:0] :
        OFS_RESET[OFS_W-1:0];

    // ***********************************************************
    // factory value capture
    // ***********************************************************
    // fuse outputs come from outside this clock, so two stages first
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            fuse_meta_reg <= '0;
            fuse_sync_reg <= '0;
        end else begin
            fuse_meta_reg <= fuse_trims;
            fuse_sync_reg <= fuse_meta_reg;
        end
    end

    // count out the sync depth, then load once
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            load_cnt_reg <= 2'h0;
            loaded_reg <= 1'b0;
        end else if (!loaded_reg) begin
            load_cnt_reg <= load_cnt_reg + 2'h1;
            loaded_reg <= fuse_load;
        end
    end

    // ***********************************************************
    // trim registers
    // ***********************************************************
    // bus writes are held off until load, so the two never collide
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            b_time_in_a_reg <= TIME_RESET;
            a_time_in_b_reg <= TIME_RESET;
            b_time_in_b_reg <= TIME_RESET;
            a_ofs_dual_a_reg <= OFS_RESET;
            a_ofs_dual_b_reg <= OFS_RESET;
            a_ofs_single_a_reg <= OFS_RESET;
        end else if (fuse_load) begin
            b_time_in_a_reg <= fuse_sync_reg.b_time_in_a;
            a_time_in_b_reg <= fuse_sync_reg.a_time_in_b;
            b_time_in_b_reg <= fuse_sync_reg.b_time_in_b;
            a_ofs_dual_a_reg <= fuse_sync_reg.a_ofs_dual_a;
            a_ofs_dual_b_reg <= fuse_sync_reg.a_ofs_dual_b;
            a_ofs_single_a_reg <= fuse_sync_reg.a_ofs_single_a;
        end else if (wr_ok) begin
            // software overwrite; lane 0 only for the byte-wide trims
            if (wr_idx == IDX_B_TIME_IN_A && wstrb_reg[0]) begin
                b_time_in_a_reg <= wdata_reg[TIME_W-1:0];
            end
            if (wr_idx == IDX_A_TIME_IN_B && wstrb_reg[0]) begin
                a_time_in_b_reg <= wdata_reg[TIME_W-1:0];
            end
            if (wr_idx == IDX_B_TIME_IN_B && wstrb_reg[0]) begin
                b_time_in_b_reg <= wdata_reg[TIME_W-1:0];
            end
            if (wr_idx == IDX_A_OFS_DUAL_A) begin
                a_ofs_dual_a_reg <= merge16(a_ofs_dual_a_reg, wdata_reg,
                    wstrb_reg);
            end
            if (wr_idx == IDX_A_OFS_DUAL_B) begin
                a_ofs_dual_b_reg <= merge16(a_ofs_dual_b_reg, wdata_reg,
                    wstrb_reg);
            end
            if (wr_idx == IDX_A_OFS_SINGLE_A) begin
                a_ofs_single_a_reg <= merge16(a_ofs_single_a_reg, wdata_reg,
                    wstrb_reg);
            end
        end
    end

    // mode control and the registered trim outputs
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            mode_ctrl_reg <= CTRL_RESET;
            core_trims_reg <= '0;
        end else begin
            if (wr_ok && wr_idx == IDX_MODE_CTRL && wstrb_reg[0]) begin
                mode_ctrl_reg <= wdata_reg[CTRL_W-1:0];
            end
            core_trims_reg <= core_trims_next;
        end
    end

    // ***********************************************************
    // axi4-lite write channel
    // ***********************************************************
    // address and data are taken in either order, one write in flight
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= 4'h0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                awaddr_reg <= axi_req.awaddr;
            end
            if (w_take) begin
                wdata_reg <= axi_req.wdata;
                wstrb_reg <= axi_req.wstrb;
            end
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            awready_reg <= loaded_reg & ~aw_held_next;
            wready_reg <= loaded_reg & ~w_held_next;
            bvalid_reg <= bvalid_next;
            if (do_write) begin
                // unmapped or misaligned words answer with an error
                bresp_reg <= is_mapped(awaddr_reg) ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // ***********************************************************
    // axi4-lite read channel
    // ***********************************************************
    // data is sampled at address take, so rdata holds while stalled
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else begin
            arready_reg <= loaded_reg & ~rvalid_next;
            rvalid_reg <= rvalid_next;
            if (ar_take) begin
                rdata_reg <= rd_word;
                rresp_reg <= is_mapped(axi_req.araddr) ? RESP_OKAY :
                    RESP_SLVERR;
            end
        end
    end

    assign axi_resp = '{awready: awready_reg, wready: wready_reg,
        bvalid: bvalid_reg, bresp: bresp_reg, arready: arready_reg,
        rvalid: rvalid_reg, rdata: rdata_reg, rresp: rresp_reg};
    assign core_trims = core_trims_reg;

    // ***********************************************************
    // checks
    // ***********************************************************
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    b_time_a_a: assert property (single_fg && !b_in_b |=>
        core_trims.b_time == $past(b_time_in_a_reg) && core_trims.b_time_valid)
        else $error("core b trim for input a not applied");
    a_time_b_a: assert property (single_fg && a_in_b |=>
        core_trims.a_time == $past(a_time_in_b_reg) && core_trims.a_time_valid)
        else $error("core a trim for input b not applied");
    b_time_b_a: assert property (single_fg && b_in_b |=>
        core_trims.b_time == $past(b_time_in_b_reg))
        else $error("core b trim for input b not applied");
    ofs_dual_a_a: assert property (dual_fg && !a_in_b |=>
        core_trims.a_offset == $past(a_ofs_dual_a_reg[OFS_W-1:0]))
        else $error("dual input a offset not applied");
    ofs_dual_b_a: assert property (dual_fg && a_in_b |=>
        core_trims.a_offset == $past(a_ofs_dual_b_reg[OFS_W-1:0]))
        else $error("dual input b offset not applied");
    ofs_single_a_a: assert property (single_fg && !a_in_b |=>
        core_trims.a_offset == $past(a_ofs_single_a_reg[OFS_W-1:0]))
        else $error("single input a offset not applied");
    time_steer_a: assert property (wr_ok &&
        wr_idx == IDX_B_TIME_IN_B && wstrb_reg[0] &&
        single_fg && b_in_b ##1 single_fg && b_in_b |=>
        core_trims.b_time == $past(wdata_reg[TIME_W-1:0], 2))
        else $error("written timing trim did not reach core b");
    fuse_load_a: assert property ($rose(loaded_reg) |->
        b_time_in_a_reg == $past(fuse_sync_reg.b_time_in_a) &&
        a_ofs_single_a_reg == $past(fuse_sync_reg.a_ofs_single_a))
        else $error("factory values not loaded");
    no_cal_a: assert property (!fg_cal |=>
        !core_trims.a_time_valid && !core_trims.b_time_valid &&
        !core_trims.a_offset_valid && core_trims.b_time == TIME_RESET)
        else $error("trim applied without foreground calibration");
    bresp_hold_a: assert property (axi_resp.bvalid && !axi_req.bready |=>
        axi_resp.bvalid && $stable(axi_resp.bresp))
        else $error("write response dropped before taken");

endmodule

// ---- pkg/trim_bank_pkg.sv ----
// constants, register map and carrier types for the converter core trim bank
package trim_bank_pkg;

    // ***********************************************************
    // bus geometry
    // ***********************************************************
    localparam int ADDR_W = 12;                 // byte address width
    localparam int DATA_W = 32;                 // bus data width
    localparam int IDX_W = 10;                  // register index width

    // ***********************************************************
    // register indexes, byte address is four times the index
    // ***********************************************************
    localparam logic [IDX_W-1:0] IDX_B_TIME_IN_A = 10'h315;
    localparam logic [IDX_W-1:0] IDX_A_TIME_IN_B = 10'h31a;
    localparam logic [IDX_W-1:0] IDX_B_TIME_IN_B = 10'h31b;
    localparam logic [IDX_W-1:0] IDX_A_OFS_DUAL_A = 10'h344;
    localparam logic [IDX_W-1:0] IDX_A_OFS_DUAL_B = 10'h346;
    localparam logic [IDX_W-1:0] IDX_A_OFS_SINGLE_A = 10'h348;
    localparam logic [IDX_W-1:0] IDX_MODE_CTRL = 10'h300;
    localparam logic [IDX_W-1:0] IDX_TRIM_STATUS = 10'h301;

    // ***********************************************************
    // field layout
    // ***********************************************************
    localparam int TIME_W = 8;                  // timing trim width
    localparam int OFS_W = 12;                  // offset correction width
    localparam int OFS_REG_W = 16;              // offset register width
    localparam int CTRL_W = 4;                  // mode control width
    localparam int CTRL_SINGLE_BIT = 0;         // 1 = single channel
    localparam int CTRL_FG_CAL_BIT = 1;         // 1 = foreground cal on
    localparam int CTRL_A_IN_B_BIT = 2;         // 1 = core a samples input b
    localparam int CTRL_B_IN_B_BIT = 3;         // 1 = core b samples input b
    localparam int STAT_W = 4;                  // status width
    localparam logic [TIME_W-1:0] TIME_RESET = 8'h00;
    localparam logic [OFS_REG_W-1:0] OFS_RESET = 16'h0000;
    localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;

    // ***********************************************************
    // responses and timing
    // ***********************************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] FUSE_LOAD_CYCLES = 2'h2;  // sync depth before load

    // ***********************************************************
    // carriers
    // ***********************************************************
    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } axi_req_s;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } axi_resp_s;

    // factory trimmed values presented by the fuse array
    typedef struct packed {
        logic [TIME_W-1:0] b_time_in_a;
        logic [TIME_W-1:0] a_time_in_b;
        logic [TIME_W-1:0] b_time_in_b;
        logic [OFS_REG_W-1:0] a_ofs_dual_a;
        logic [OFS_REG_W-1:0] a_ofs_dual_b;
        logic [OFS_REG_W-1:0] a_ofs_single_a;
    } fuse_trims_s;

    // trims applied to the converter cores
    typedef struct packed {
        logic [TIME_W-1:0] a_time;
        logic a_time_valid;
        logic [TIME_W-1:0] b_time;
        logic b_time_valid;
        logic [OFS_W-1:0] a_offset;
        logic a_offset_valid;
    } core_trims_s;

endpackage

// ---- sim/test_converter_core_trim_bank.sv ----
// self-checking testbench for the converter core trim bank
`timescale 1ns/1ps

module test_converter_core_trim_bank;
    import trim_bank_pkg::*;

    // ***********************************************************
    // signals and bench state
    // ***********************************************************
    logic clock;                    // 10 mhz bench clock
    logic rstn;                     // active low reset
    axi_req_s req;                  // master side of the bus
    axi_resp_s rsp;                 // slave answers
    fuse_trims_s fuse;              // factory values, static from time zero
    core_trims_s trims;             // trims routed to the cores
    int n_mismatch;                 // mismatches seen
    int tests_run;                  // comparisons made
    logic [15:0] shadow [6];        // expected register contents
    logic [IDX_W-1:0] idx_tab [6];  // register indexes in map order
    logic [31:0] v;                 // scratch data
    int k;                          // scratch index
    int c;                          // mode loop counter

    converter_core_trim_bank i_dut (
        .clock(clock),
        .rstn(rstn),
        .axi_req(req),
        .axi_resp(rsp),
        .fuse_trims(fuse),
        .core_trims(trims)
    );

    // ***********************************************************
    // clock
    // ***********************************************************
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ***********************************************************
    // checking and closing
    // ***********************************************************
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic final_report();
        $display("mismatches %0d, comparisons %0d", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // a wait that runs out counts as a mismatch and ends the run
    task automatic timed_out();
        n_mismatch++;
        $display("Error at %0t: wait timed out got %h expected %h", $time,
            32'h0, 32'h1);
        final_report();
    endtask

    // ***********************************************************
    // bus tasks, each opens one edge later so no signal is set twice
    // ***********************************************************
    task automatic bus_wr(input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, input logic [3:0] s,
        input logic [1:0] er);
        int n;
        logic [1:0] r;
        r = 2'h3;
        @(posedge clock);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= s;
        req.bready <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge clock);
            // each channel released only at its own taking edge
            if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
            if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid && req.bready) begin
                r = rsp.bresp;
                req.bready <= 1'b0;
                break;
            end
        end
        if (n == 200) timed_out();
        check({30'h0, r}, {30'h0, er});
    endtask

    task automatic bus_rd(input logic [ADDR_W-1:0] a,
        input logic [31:0] ed, input logic [1:0] er);
        int n;
        logic [1:0] r;
        logic [31:0] d;
        r = 2'h3;
        d = 32'h0;
        @(posedge clock);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        for (n = 0; n < 200; n++) begin
            @(posedge clock);
            if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid && req.rready) begin
                d = rsp.rdata;
                r = rsp.rresp;
                req.rready <= 1'b0;
                break;
            end
        end
        if (n == 200) timed_out();
        check({30'h0, r}, {30'h0, er});
        if (er === RESP_OKAY) check(d, ed);
    endtask

    // ***********************************************************
    // expected routing of trims for a mode control value
    // ***********************************************************
    function automatic core_trims_s exp_trims(input logic [3:0] m);
        core_trims_s e;
        logic on;
        e = '0;
        on = m[CTRL_FG_CAL_BIT];
        if (on && m[CTRL_SINGLE_BIT] && m[CTRL_A_IN_B_BIT]) begin
            e.a_time = shadow[1][7:0];
            e.a_time_valid = 1'b1;
        end
        if (on && m[CTRL_SINGLE_BIT]) begin
            e.b_time = m[CTRL_B_IN_B_BIT] ? shadow[2][7:0] : shadow[0][7:0];
            e.b_time_valid = 1'b1;
        end
        // single channel with core a on input b has no offset here
        if (on && !(m[CTRL_SINGLE_BIT] && m[CTRL_A_IN_B_BIT])) begin
            e.a_offset_valid = 1'b1;
            e.a_offset = m[CTRL_SINGLE_BIT] ? shadow[5][11:0] :
                (m[CTRL_A_IN_B_BIT] ? shadow[4][11:0] : shadow[3][11:0]);
        end
        return e;
    endfunction

    function automatic logic [ADDR_W-1:0] ba(input logic [IDX_W-1:0] i);
        return {i, 2'b00};
    endfunction

    // read one trim register back against its expected contents
    task automatic rd_reg(input int i);
        bus_rd(ba(idx_tab[i]), {16'h0, shadow[i]}, RESP_OKAY);
    endtask

    // ***********************************************************
    // main sequence
    // ***********************************************************
    initial begin
        n_mismatch = 0;
        tests_run = 0;
        void'($urandom(32'hffba));
        rstn = 1'b0;
        req = '0;
        fuse = 72'({$urandom(), $urandom(), $urandom()});
        idx_tab = '{IDX_B_TIME_IN_A, IDX_A_TIME_IN_B, IDX_B_TIME_IN_B,
            IDX_A_OFS_DUAL_A, IDX_A_OFS_DUAL_B, IDX_A_OFS_SINGLE_A};
        shadow = '{{8'h00, fuse.b_time_in_a}, {8'h00, fuse.a_time_in_b},
            {8'h00, fuse.b_time_in_b}, fuse.a_ofs_dual_a, fuse.a_ofs_dual_b,
            fuse.a_ofs_single_a};
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        // factory values appear once loading is done
        for (k = 0; k < 6; k++) begin
            bus_rd(ba(idx_tab[k]), {16'h0, shadow[k]}, RESP_OKAY);
        end
        bus_rd(ba(IDX_TRIM_STATUS), 32'h8, RESP_OKAY);
        bus_wr(ba(IDX_TRIM_STATUS), 32'h7, 4'hf, RESP_OKAY);
        bus_rd(ba(IDX_TRIM_STATUS), 32'h8, RESP_OKAY);
        bus_rd(ba(IDX_MODE_CTRL), 32'(CTRL_RESET), RESP_OKAY);
        // all ones first, so narrow widths must mask, then random words
        for (c = 0; c < 2; c++) begin
            for (k = 0; k < 6; k++) begin
                v = (c == 0) ? 32'hffffffff : $urandom();
                shadow[k] = (k < 3) ? {8'h00, v[7:0]} : v[15:0];
                bus_wr(ba(idx_tab[k]), v, 4'hf, RESP_OKAY);
            end
            rd_reg(0);
            rd_reg(1);
            rd_reg(2);
            rd_reg(3);
            rd_reg(4);
            rd_reg(5);
        end
        // a narrow register ignores a write without its low lane
        bus_wr(ba(idx_tab[0]), 32'h5a, 4'he, RESP_OKAY);
        bus_rd(ba(idx_tab[0]), {16'h0, shadow[0]}, RESP_OKAY);
        // unmapped and misaligned places refuse and store nothing
        bus_wr(12'h010, 32'h1234, 4'hf, RESP_SLVERR);
        bus_rd(12'h010, 32'h0, RESP_SLVERR);
        bus_wr({IDX_A_OFS_DUAL_A, 2'b10}, 32'h0abc, 4'hf, RESP_SLVERR);
        bus_rd(ba(idx_tab[3]), {16'h0, shadow[3]}, RESP_OKAY);
        // every mode, with a random trim changed before each one
        for (c = 0; c < 16; c++) begin
            k = $urandom_range(5, 0);
            v = $urandom();
            shadow[k] = (k < 3) ? {8'h00, v[7:0]} : v[15:0];
            bus_wr(ba(idx_tab[k]), v, 4'hf, RESP_OKAY);
            bus_wr(ba(IDX_MODE_CTRL), 32'(c), 4'hf, RESP_OKAY);
            repeat (2) @(posedge clock);
            check(32'(trims), 32'(exp_trims(4'(c))));
        end
        // a trim rewritten while its own mode stands reaches the core
        v = $urandom();
        shadow[2] = {8'h00, v[7:0]};
        bus_wr(ba(idx_tab[2]), v, 4'hf, RESP_OKAY);
        repeat (2) @(posedge clock);
        check(32'(trims), 32'(exp_trims(4'hf)));
        final_report();
    end
endmodule
